// file: hw/timer_pkg.sv
/*
  Shared constants and types for the compact 10-bit timer with PWM.
  Assumes a single AHB-Lite master and whole-word (32-bit) transfers.
*/
`default_nettype none

package timer_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h04;
  localparam logic [7:0] ADDR_COUNTER_LOW   = 8'h08;
  localparam logic [7:0] ADDR_COUNTER_HIGH  = 8'h0c;
  localparam logic [7:0] ADDR_MATCH_A_LOW   = 8'h10;
  localparam logic [7:0] ADDR_MATCH_A_HIGH  = 8'h14;
  localparam logic [7:0] ADDR_FLAGS         = 8'h18;

  // Field positions in the first control register.
  localparam int POS_PAUSE       = 7;
  localparam int POS_COUNTER_ON  = 3;
  localparam int POS_PERIOD_LSB  = 0;

  // Field positions in the second control register (control_reg_two).
  localparam int POS_MODE_LSB    = 6;
  localparam int POS_ACTION_LSB  = 4;
  localparam int POS_LEVEL_CTRL  = 3;
  localparam int POS_INVERT      = 2;
  localparam int POS_SWAP        = 1;
  localparam int POS_CLEAR_SEL   = 0;

  // Field positions in the flag register.
  localparam int POS_FLAG_A      = 0;
  localparam int POS_FLAG_P      = 1;

  // Values after reset.
  localparam logic [7:0]  RESET_CONTROL = 8'h00;
  localparam logic [9:0]  RESET_COUNT   = 10'h000;
  localparam logic [9:0]  RESET_MATCH_A = 10'h000;

  // Counting spans in counter clocks.
  localparam logic [10:0] PERIOD_UNIT   = 11'h080;
  localparam logic [10:0] FULL_SPAN     = 11'h400;
  localparam int          PERIOD_SHIFT  = 7;

  // Mode-select codes.
  localparam logic [1:0] CODE_COMPARE = 2'h0;
  localparam logic [1:0] CODE_PWM     = 2'h2;
  localparam logic [1:0] CODE_TIMER   = 2'h3;

  // Pin-action codes in compare-match output mode.
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Pin-action codes in PWM mode.
  localparam logic [1:0] PWM_FORCE_OFF = 2'h0;
  localparam logic [1:0] PWM_FORCE_ON  = 2'h1;
  localparam logic [1:0] PWM_WAVE      = 2'h2;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_PWM,
    MODE_TIMER,
    MODE_UNDEF
  } mode_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic [7:0] controlOne;
    logic [7:0] controlTwo;
    logic [9:0] matchA;
  } regs_t;

endpackage : timer_pkg

`default_nettype wire

// file: hw/compact_timer.sv
/*
  Compact 10-bit count-up timer with comparators A and P, offering
  compare-match output, timer/counter and edge-aligned PWM modes.
  Assumes an AHB-Lite master on the same clock; the counter advances
  once per clk while switched on and not paused.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Clear-select high: match A clears counter.
// - Clear-select low: match P clears counter.
// - PWM mode ignores the clear-select bit.
// - Counter readable as low and high byte.
// - Compare value A is read/write, resets zero.
// - Mode 00 compare, 11 timer, 10 PWM.
// - Clear-select low raises both match flags.
// - Clear-select high raises no P flag outside PWM mode.
// - Compare A zero: overflow at 3FF, no flag.
// - Compare mode pin changes only on A match or counter-on rising.
// - A match drives pin high, low or toggles.
// - Counter-on rising loads pin initial level.
// - Timer mode equals compare mode, pin undriven.
// - PWM: one value sets period, other duty.
// - PWM raises both flags on their matches.
// - PWM level, enable and invert control pin.
// - Swap clear: period is P times 128, or 1024 for P zero.
// - Duty at or above period gives full duty.
// - Swap set: A is period, P duty.
// - Compare actions: 01 low, 10 high, 11 toggle.
// - PWM actions: 00 inactive, 01 active, 10 wave.
// - Counter-on rising clears counter; off holds it.
module compact_timer
  import timer_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire timer_pkg::ahb_req_t busReq,
  output var  timer_pkg::ahb_rsp_t busRsp,
  output var  logic                timerPin,
  output var  logic                timerPinOe,
  output var  logic                matchAFlag,
  output var  logic                matchPFlag
);

  import timer_pkg::*;

  typedef struct packed {
    regs_t       regs;
    logic [9:0]  count;
    logic        onPrev;
    logic        pinLevel;
    logic        flagA;
    logic        flagP;
    logic        readPend;
    logic        writePend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        ready;
    logic        pinOut;
    logic        pinOe;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Turns the two mode-select bits into a mode.
  function automatic mode_t decodeMode(input logic [1:0] code);
    mode_t m;
    unique case (code)
      CODE_COMPARE: m = MODE_COMPARE;
      CODE_PWM:     m = MODE_PWM;
      CODE_TIMER:   m = MODE_TIMER;
      default:      m = MODE_UNDEF;
    endcase
    return m;
  endfunction : decodeMode

  // Turns a 3-bit period value into a span of counter clocks; zero means the full range.
  function automatic logic [10:0] spanOf(input logic [2:0] value);
    logic [10:0] span;
    span = (value == 3'h0) ? FULL_SPAN : (11'({8'h00, value}) << PERIOD_SHIFT);
    return span;
  endfunction : spanOf

  mode_t       mode;
  logic        counterOn;
  logic        paused;
  logic        onRise;
  logic        clearSel;
  logic        swap;
  logic        levelCtrl;
  logic        invert;
  logic [1:0]  action;
  logic [2:0]  periodBits;
  logic [10:0] countInc;
  logic [10:0] spanP;
  logic [10:0] spanA;
  logic [10:0] periodSpan;
  logic [10:0] dutySpan;
  logic        hitA;
  logic        hitP;
  logic        clearCount;
  logic        setA;
  logic        setP;
  logic        clrA;
  logic        clrP;
  logic        pwmActive;
  logic        pwmLevel;
  logic        accept;

  always_comb begin
    s_d        = s_q;
    mode       = decodeMode(s_q.regs.controlTwo[POS_MODE_LSB +: 2]);
    counterOn  = s_q.regs.controlOne[POS_COUNTER_ON];
    paused     = s_q.regs.controlOne[POS_PAUSE];
    periodBits = s_q.regs.controlOne[POS_PERIOD_LSB +: 3];
    clearSel   = s_q.regs.controlTwo[POS_CLEAR_SEL];
    swap       = s_q.regs.controlTwo[POS_SWAP];
    levelCtrl  = s_q.regs.controlTwo[POS_LEVEL_CTRL];
    invert     = s_q.regs.controlTwo[POS_INVERT];
    action     = s_q.regs.controlTwo[POS_ACTION_LSB +: 2];
    onRise     = counterOn & ~s_q.onPrev;
    s_d.onPrev = counterOn;

    // Comparators look at the count that the next tick would reach.
    countInc   = 11'({1'b0, s_q.count}) + 11'h001;
    spanP      = spanOf(periodBits);
    spanA      = (s_q.regs.matchA == RESET_MATCH_A) ? FULL_SPAN : 11'({1'b0, s_q.regs.matchA});
    hitP       = (countInc == spanP);
    hitA       = (countInc[9:0] == s_q.regs.matchA) && (s_q.regs.matchA != RESET_MATCH_A);

    // Period and duty roles in PWM mode.
    periodSpan = swap ? spanA : spanP;
    dutySpan   = swap ? spanP : 11'({1'b0, s_q.regs.matchA});

    clearCount = 1'b0;
    setA       = 1'b0;
    setP       = 1'b0;
    pwmLevel   = 1'b0;
    pwmActive  = 1'b0;

    if (onRise) begin
      s_d.count    = RESET_COUNT;
      s_d.pinLevel = levelCtrl;
    end else if (counterOn && !paused) begin
      unique case (mode)
        MODE_PWM: begin
          clearCount = (countInc == periodSpan);
          setA       = hitA;
          setP       = hitP;
        end
        MODE_COMPARE, MODE_TIMER, MODE_UNDEF: begin
          if (clearSel) begin
            clearCount = hitA;
            setA       = hitA;
          end else begin
            clearCount = hitP;
            setA       = hitA;
            setP       = hitP;
          end
          if (setA && mode == MODE_COMPARE) begin
            unique case (action)
              ACT_NONE:   s_d.pinLevel = s_q.pinLevel;
              ACT_LOW:    s_d.pinLevel = 1'b0;
              ACT_HIGH:   s_d.pinLevel = 1'b1;
              ACT_TOGGLE: s_d.pinLevel = ~s_q.pinLevel;
            endcase
          end
        end
      endcase
      // A clear at the top of the range is the same as a natural wrap.
      s_d.count = clearCount ? RESET_COUNT : countInc[9:0];
    end

    // Waveform is active while the count is below the duty span.
    pwmActive = (11'({1'b0, s_d.count}) < dutySpan);
    unique case (action)
      PWM_FORCE_OFF: pwmLevel = ~levelCtrl;
      PWM_FORCE_ON:  pwmLevel = levelCtrl;
      PWM_WAVE:      pwmLevel = pwmActive ? levelCtrl : ~levelCtrl;
      default:       pwmLevel = ~levelCtrl;
    endcase

    unique case (mode)
      MODE_COMPARE: begin
        s_d.pinOut = s_d.pinLevel ^ invert;
        s_d.pinOe  = 1'b1;
      end
      MODE_PWM: begin
        s_d.pinOut = pwmLevel ^ invert;
        s_d.pinOe  = 1'b1;
      end
      MODE_TIMER, MODE_UNDEF: begin
        s_d.pinOut = 1'b0;
        s_d.pinOe  = 1'b0;
      end
    endcase

    // Bus data phase: writes land here, after the address phase was taken.
    clrA = 1'b0;
    clrP = 1'b0;
    if (s_q.writePend) begin
      unique case (s_q.addr)
        ADDR_CONTROL_ONE:  s_d.regs.controlOne = busReq.hwdata[7:0];
        ADDR_CONTROL_TWO:  s_d.regs.controlTwo = busReq.hwdata[7:0];
        ADDR_MATCH_A_LOW:  s_d.regs.matchA[7:0] = busReq.hwdata[7:0];
        ADDR_MATCH_A_HIGH: s_d.regs.matchA[9:8] = busReq.hwdata[1:0];
        ADDR_FLAGS: begin
          clrA = busReq.hwdata[POS_FLAG_A];
          clrP = busReq.hwdata[POS_FLAG_P];
        end
        default: ;
      endcase
    end

    // A match in the clearing cycle still sets its flag.
    s_d.flagA = (s_q.flagA & ~clrA) | setA;
    s_d.flagP = (s_q.flagP & ~clrP) | setP;

    // Reads are answered one cycle after the address phase, from current state.
    if (s_q.readPend) begin
      s_d.rdata = 32'h0000_0000;
      unique case (s_q.addr)
        ADDR_CONTROL_ONE:  s_d.rdata[7:0] = s_q.regs.controlOne;
        ADDR_CONTROL_TWO:  s_d.rdata[7:0] = s_q.regs.controlTwo;
        ADDR_COUNTER_LOW:  s_d.rdata[7:0] = s_q.count[7:0];
        ADDR_COUNTER_HIGH: s_d.rdata[1:0] = s_q.count[9:8];
        ADDR_MATCH_A_LOW:  s_d.rdata[7:0] = s_q.regs.matchA[7:0];
        ADDR_MATCH_A_HIGH: s_d.rdata[1:0] = s_q.regs.matchA[9:8];
        ADDR_FLAGS: begin
          s_d.rdata[POS_FLAG_A] = s_q.flagA;
          s_d.rdata[POS_FLAG_P] = s_q.flagP;
        end
        default: ;
      endcase
    end

    // Bus address phase.
    accept        = busReq.hsel & busReq.htrans[1] & busReq.hready;
    s_d.writePend = accept & busReq.hwrite;
    s_d.readPend  = accept & ~busReq.hwrite;
    s_d.ready     = ~(accept & ~busReq.hwrite);
    if (accept) begin
      s_d.addr = busReq.haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.regs.controlOne <= RESET_CONTROL;
      s_q.regs.controlTwo <= RESET_CONTROL;
      s_q.regs.matchA     <= RESET_MATCH_A;
      s_q.count           <= RESET_COUNT;
      s_q.onPrev          <= 1'b0;
      s_q.pinLevel        <= 1'b0;
      s_q.flagA           <= 1'b0;
      s_q.flagP           <= 1'b0;
      s_q.readPend        <= 1'b0;
      s_q.writePend       <= 1'b0;
      s_q.addr            <= 8'h00;
      s_q.rdata           <= 32'h0000_0000;
      s_q.ready           <= 1'b1;
      s_q.pinOut          <= 1'b0;
      s_q.pinOe           <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign busRsp.hrdata    = s_q.rdata;
  assign busRsp.hreadyout = s_q.ready;
  assign busRsp.hresp     = 1'b0;
  assign timerPin         = s_q.pinOut;
  assign timerPinOe       = s_q.pinOe;
  assign matchAFlag       = s_q.flagA;
  assign matchPFlag       = s_q.flagP;

endmodule : compact_timer

`default_nettype wire

// file: tb/compact_timer_assertions.sv
/*
  Port checker for the compact timer: bus timing, flags and pin enable.
  Assumes the bus hready is wired to the timer's own hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module compact_timer_assertions (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire timer_pkg::ahb_req_t busReq,
  input wire timer_pkg::ahb_rsp_t busRsp,
  input wire logic                timerPin,
  input wire logic                timerPinOe,
  input wire logic                matchAFlag,
  input wire logic                matchPFlag
);
  import timer_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic       taken;
  logic       flagWr_q;
  logic       ctlWr_q;
  logic [7:0] ctl2_q;
  logic [1:0] quiet_q;
  assign taken = busReq.hsel && busReq.htrans[1] && busReq.hready;
  // Shadow of the second control register, updated in the write data phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagWr_q <= 1'b0;
      ctlWr_q <= 1'b0;
      ctl2_q <= 8'h00;
      quiet_q <= 2'h0;
    end else begin
      flagWr_q <= taken && busReq.hwrite && busReq.haddr[7:0] == ADDR_FLAGS;
      ctlWr_q <= taken && busReq.hwrite && busReq.haddr[7:0] == ADDR_CONTROL_TWO;
      if (ctlWr_q) begin
        ctl2_q <= busReq.hwdata[7:0];
      end
      quiet_q <= ctlWr_q ? 2'h0 : (quiet_q == 2'h3 ? quiet_q : quiet_q + 2'h1);
    end
  end
  sequence readTaken;
    taken && !busReq.hwrite;
  endsequence
  sequence waitState;
    !busRsp.hreadyout ##1 busRsp.hreadyout;
  endsequence
  a_read_wait: assert property (readTaken |=> waitState)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (taken && busReq.hwrite |=> busRsp.hreadyout)
    else $error("write inserted a wait state");
  a_resp_okay: assert property (busRsp.hresp == 1'b0)
    else $error("response not okay");
  a_upper_zero: assert property ($rose(busRsp.hreadyout) |-> busRsp.hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_flag_a_hold: assert property ($fell(matchAFlag) |-> $past(flagWr_q && busReq.hwdata[0]))
    else $error("match A flag dropped without clear");
  a_flag_p_hold: assert property ($fell(matchPFlag) |-> $past(flagWr_q && busReq.hwdata[1]))
    else $error("match P flag dropped without clear");
  a_oe_mode: assert property (quiet_q == 2'h3 |-> timerPinOe == !ctl2_q[POS_MODE_LSB])
    else $error("pin enable does not follow mode");
  a_no_p_flag: assert property ($rose(matchPFlag) |->
      !($past(ctl2_q[0]) && $past(ctl2_q[7:6]) != CODE_PWM))
    else $error("match P flag with clear select high");
endmodule : compact_timer_assertions
`default_nettype wire

// file: tb/test_compact_timer.sv
/*
  Self-checking bench for the compact timer over AHB-Lite.
  Assumes one bus master here and hready looped back from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module test_compact_timer;
  import timer_pkg::*;
  logic     clk;
  logic     rst_n;
  ahb_req_t req;
  ahb_req_t busReq;
  ahb_rsp_t busRsp;
  logic     timerPin;
  logic     timerPinOe;
  logic     matchAFlag;
  logic     matchPFlag;
  int       fails;
  int       check_count;
  int       hi;
  int       per;
  logic [31:0] seed;
  logic [9:0]  a;
  logic [7:0]  pc[3];
  int          pa[3];
  compact_timer dut (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp),
    .timerPin(timerPin), .timerPinOe(timerPinOe), .matchAFlag(matchAFlag),
    .matchPFlag(matchPFlag));
  always_comb begin
    busReq = req;
    busReq.hready = busRsp.hreadyout;
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int span(int p);
    return p == 0 ? 1024 : p * 128;
  endfunction : span
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    req.hsel <= 1'b1;
    req.haddr <= {24'h0, ad};
    req.htrans <= 2'b10;
    req.hwrite <= 1'b1;
    do @(posedge clk); while (busRsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge clk); while (busRsp.hreadyout !== 1'b1);
  endtask : wr
  task automatic rdc(logic [7:0] ad, logic [31:0] exp, string name);
    req.hsel <= 1'b1;
    req.haddr <= {24'h0, ad};
    req.htrans <= 2'b10;
    req.hwrite <= 1'b0;
    do @(posedge clk); while (busRsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    do @(posedge clk); while (busRsp.hreadyout !== 1'b1);
    check(name, exp, busRsp.hrdata);
  endtask : rdc
  task automatic setup(logic [7:0] ctl2, logic [9:0] av, logic [2:0] p);
    wr(ADDR_CONTROL_ONE, 32'h0);
    wr(ADDR_CONTROL_TWO, {24'h0, ctl2});
    wr(ADDR_MATCH_A_LOW, {24'h0, av[7:0]});
    wr(ADDR_MATCH_A_HIGH, {30'h0, av[9:8]});
    wr(ADDR_FLAGS, 32'h3);
    wr(ADDR_CONTROL_ONE, {28'h0, 1'b1, p});
  endtask : setup
  // Measures one high time and one full period of the pin in clocks.
  task automatic measure();
    int n;
    n = 0;
    while (timerPin !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
    while (timerPin !== 1'b1 && n < 6000) begin @(posedge clk); n++; end
    hi = 0;
    while (timerPin === 1'b1 && hi < 3000) begin @(posedge clk); hi++; end
    per = hi;
    while (timerPin === 1'b0 && per < 6000) begin @(posedge clk); per++; end
  endtask : measure
  task automatic hold(logic exp, string name);
    int n;
    n = 0;
    repeat (300) begin @(posedge clk); if (timerPin === exp) n++; end
    check(name, 300, n);
  endtask : hold
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
  initial begin
    req = '0;
    rst_n = 1'b0;
    seed = 32'hf11cf906;
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0, "reset value");
    a = 10'(rnd());
    wr(ADDR_MATCH_A_LOW, {24'h0, a[7:0]});
    wr(ADDR_MATCH_A_HIGH, {30'h0, a[9:8]});
    rdc(ADDR_MATCH_A_LOW, {24'h0, a[7:0]}, "compare low");
    rdc(ADDR_MATCH_A_HIGH, {30'h0, a[9:8]}, "compare high");
    wr(ADDR_COUNTER_LOW, 32'hff);
    rdc(ADDR_COUNTER_LOW, 32'h0, "counter read only");
    setup(8'h30, 10'd50, 3'd1);
    measure();
    check("toggle by period", span(1), hi);
    rdc(ADDR_FLAGS, 32'h3, "both flags");
    check("pin enable compare", 1, timerPinOe);
    a = 10'(rnd() % 200 + 150);
    setup(8'h31, a, 3'd1);
    measure();
    check("toggle by compare A", a, hi);
    rdc(ADDR_FLAGS, 32'h1, "only A flag");
    setup(8'h31, 10'd0, 3'd1);
    repeat (1100) @(posedge clk);
    rdc(ADDR_FLAGS, 32'h0, "no flag at wrap");
    for (int act = 0; act < 3; act++) begin
      setup({2'b00, 2'(act), act != 2, 3'b000}, 10'd60, 3'd1);
      repeat (2) @(posedge clk);
      check("initial level", act != 2, timerPin);
      repeat (100) @(posedge clk);
      hold(act != 1, "pin action");
    end
    setup(8'hc0, 10'd50, 3'd1);
    repeat (300) @(posedge clk);
    check("pin enable timer", 0, timerPinOe);
    rdc(ADDR_FLAGS, 32'h3, "timer flags");
    pc = '{8'ha9, 8'haa, 8'hac};
    pa = '{rnd() % 200 + 20, 300, 40};
    for (int k = 0; k < 3; k++) begin
      setup(pc[k], 10'(pa[k]), k == 0 ? 3'd2 : 3'd1);
      measure();
      per = per == (pc[k][1] ? pa[k] : span(k == 0 ? 2 : 1)) ? 0 : per;
      check("pwm period", 0, per);
      check("pwm high time", k == 0 ? pa[0] : k == 1 ? 128 : 88, hi);
      rdc(ADDR_FLAGS, 32'h3, "pwm flags");
    end
    pc = '{8'ha8, 8'h88, 8'h98};
    for (int k = 0; k < 3; k++) begin
      setup(pc[k], 10'd500, 3'd1);
      hold(k != 1, "pwm fixed level");
    end
    wrap_up();
  end
endmodule : test_compact_timer
bind compact_timer compact_timer_assertions chk (.clk(clk), .rst_n(rst_n), .busReq(busReq),
  .busRsp(busRsp), .timerPin(timerPin), .timerPinOe(timerPinOe), .matchAFlag(matchAFlag),
  .matchPFlag(matchPFlag));
`default_nettype wire
